//--- rtl/pibrd_decode.sv
// Register access decoder and configuration spaces of functions 0 to 2 of the bridge
`timescale 1ns/10ps
`include "pibrd_consts.svh"

module pibrd_decode
   import pibrd_pkg::*;
#(
   parameter logic [15:0] MAKER_ID    = 16'h1234, // Arbitrary value
   parameter logic [15:0] PART_ID0    = 16'h0001, // Arbitrary value
   parameter logic [15:0] PART_ID1    = 16'h0002, // Arbitrary value
   parameter logic [15:0] PART_ID2    = 16'h0003, // Arbitrary value
   parameter logic [7:0]  REVISION_ID = 8'h01,    // Arbitrary value
   parameter logic [23:0] CLASS0      = 24'h060100,
   parameter logic [23:0] CLASS1      = 24'h010180,
   parameter logic [23:0] CLASS2      = 24'h0C0300,
   parameter logic [7:0]  HEADER0     = 8'h80
)(
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_srst,
   // Request
   input  wire logic        i_req_valid,
   input  wire pibrd_req_t  i_req,
   // Status events
   input  wire logic [15:0] i_status_set,
   // Completion
   output logic             o_done,
   output logic             o_claim,
   output pibrd_dec_t       o_decode,
   output logic [31:0]      o_rdata,
   output logic             o_isa_byte_target,
   // ISA broadcast
   output logic             o_isa_bcast,
   output logic             o_isa_bcast_wr,
   // Internal unit access
   output pibrd_unit_t      o_unit_sel,
   output logic             o_unit_wr,
   output logic [15:0]      o_unit_addr,
   output logic [31:0]      o_unit_wdata,
   output logic [3:0]       o_unit_be,
   // Decode controls
   output logic             o_alias_en
);

   logic [15:0] cmd0_q;
   logic [15:0] cmd1_q;
   logic [15:0] cmd2_q;
   logic [15:0] stat0_q;
   logic [15:0] stat_d;
   logic [15:0] disk_busmaster_base_address_q;
   logic [15:0] serial_q;
   logic [7:0]  dev_q [8'h40:8'hAF];
   logic [31:0] cfg_rd;
   logic        alias_en;
   logic [15:0] io_addr;
   pibrd_unit_t unit;
   pibrd_dec_t  dec;
   logic        isa_ok;
   logic        bcast;
   logic [1:0]  lane;

   function automatic logic dev_writable(input logic [7:0] off);
      case (off)
         8'h4C, 8'h4E, 8'h4F, 8'h5C, 8'h5D, 8'h60, 8'h61, 8'h62, 8'h63,
         8'h69, 8'h6A, 8'h6B, 8'h70, 8'h71, 8'h76, 8'h77, 8'h78, 8'h79,
         8'h80, 8'h82, 8'hA0, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7,
         8'hA8, 8'hAA, 8'hAB, 8'hAC, 8'hAE: dev_writable = 1'b1;
         default: dev_writable = 1'b0;
      endcase
   endfunction : dev_writable

   function automatic logic is_dma(input logic [15:0] a);
      is_dma = (a[15:5] == 11'h000 && a[4] == 1'b0) ||
               (a[15:8] == 8'h00 && a[7:4] == 4'h8) ||
               (a[15:8] == 8'h00 && a[7:5] == 3'h6);
   endfunction : is_dma

   function automatic logic is_compat(input logic [15:0] a);
      case (a)
         16'h0020, 16'h0021, 16'h0040, 16'h0041, 16'h0042, 16'h0043,
         16'h0060, 16'h0061, 16'h0070, 16'h00A0, 16'h00A1,
         16'h00F0: is_compat = 1'b1;
         default:  is_compat = 1'b0;
      endcase
   endfunction : is_compat

   function automatic logic isa_reach(input logic [15:0] a);
      case (a)
         16'h0020, 16'h0021, 16'h0040, 16'h0041, 16'h0042, 16'h0043,
         16'h0060, 16'h0061: isa_reach = 1'b1;
         default:            isa_reach = 1'b0;
      endcase
   endfunction : isa_reach

   function automatic logic bcast_wr_port(input logic [7:0] a);
      case (a[3:0])
         4'h0, 4'h4, 4'h5, 4'h6, 4'h8, 4'hC, 4'hD, 4'hE: bcast_wr_port = 1'b1;
         default: bcast_wr_port = 1'b0;
      endcase
   endfunction : bcast_wr_port

   function automatic logic [1:0] low_lane(input logic [3:0] be);
      if (be[0]) begin
         low_lane = 2'h0;
      end else if (be[1]) begin
         low_lane = 2'h1;
      end else if (be[2]) begin
         low_lane = 2'h2;
      end else begin
         low_lane = 2'h3;
      end
   endfunction : low_lane

   assign alias_en = dev_q[`PIBRD_CFG_RECOVERY][`PIBRD_RECOV_ALIAS_EN];
   assign lane     = low_lane(i_req.be);
   assign io_addr  = {i_req.addr[15:2], lane};

   // I/O space decode
   always_comb begin
      unit   = PIBRD_UNIT_NONE;
      dec    = PIBRD_DEC_NONE;
      isa_ok = 1'b1;
      bcast  = 1'b0;
      if (i_req.isa_master) begin
         isa_ok = isa_reach(io_addr);
      end
      if (io_addr == `PIBRD_PM_PORT_A || io_addr == `PIBRD_PM_PORT_B) begin
         unit = PIBRD_UNIT_PM;
         dec  = PIBRD_DEC_POSITIVE;
      end else if (is_dma(io_addr) || (alias_en && io_addr[15:4] == 12'h009)) begin
         unit = PIBRD_UNIT_DMA;
         dec  = PIBRD_DEC_SUBTRACTIVE;
      end else if (is_compat(io_addr)) begin
         unit = PIBRD_UNIT_COMPAT;
         dec  = PIBRD_DEC_POSITIVE;
      end else if (cmd1_q[`PIBRD_CMD_IO_EN] &&
                   i_req.addr[15:`PIBRD_BM_WIN_BITS] == disk_busmaster_base_address_q[15:`PIBRD_BM_WIN_BITS]) begin
         unit = PIBRD_UNIT_DISK_BM;
         dec  = PIBRD_DEC_POSITIVE;
      end else if (cmd2_q[`PIBRD_CMD_IO_EN] &&
                   i_req.addr[15:`PIBRD_SERIAL_WIN_BITS] ==
                   serial_q[15:`PIBRD_SERIAL_WIN_BITS]) begin
         unit = PIBRD_UNIT_SERIAL;
         dec  = PIBRD_DEC_POSITIVE;
      end
      if (i_req.isa_master && (!isa_ok || unit == PIBRD_UNIT_DISK_BM ||
                               unit == PIBRD_UNIT_SERIAL)) begin
         unit = PIBRD_UNIT_NONE;
         dec  = PIBRD_DEC_NONE;
      end
      if (!i_req.isa_master && io_addr[15:8] == 8'h00) begin
         if (io_addr[7:0] == 8'h70 || io_addr[7:0] == 8'hF0) begin
            bcast = 1'b1;
         end else if (i_req.wr && io_addr[7:4] == 4'h8) begin
            bcast = bcast_wr_port(io_addr[7:0]);
         end else if (i_req.wr && io_addr[7:4] == 4'h9) begin
            bcast = bcast_wr_port(io_addr[7:0]);
         end
      end
   end

   // Configuration read data
   always_comb begin
      logic [7:0] off;
      logic [7:0] b;
      cfg_rd = 32'h0000_0000;
      off    = 8'h00;
      b      = 8'h00;
      for (int k = 0; k < 4; k++) begin
         off = {i_req.addr[7:2], k[1:0]};
         b   = 8'h00;
         case (i_req.func)
            3'h0: begin
               case (off)
                  8'h00: b = MAKER_ID[7:0];
                  8'h01: b = MAKER_ID[15:8];
                  8'h02: b = PART_ID0[7:0];
                  8'h03: b = PART_ID0[15:8];
                  8'h04: b = cmd0_q[7:0];
                  8'h05: b = cmd0_q[15:8];
                  8'h06: b = stat0_q[7:0];
                  8'h07: b = stat0_q[15:8];
                  8'h08: b = REVISION_ID;
                  8'h09: b = CLASS0[7:0];
                  8'h0A: b = CLASS0[15:8];
                  8'h0B: b = CLASS0[23:16];
                  8'h0E: b = HEADER0;
                  default: begin
                     if (off >= `PIBRD_CFG_DEV_LO && off <= `PIBRD_CFG_DEV_HI) begin
                        b = dev_q[off];
                     end
                  end
               endcase
            end
            3'h1: begin
               case (off)
                  8'h00: b = MAKER_ID[7:0];
                  8'h01: b = MAKER_ID[15:8];
                  8'h02: b = PART_ID1[7:0];
                  8'h03: b = PART_ID1[15:8];
                  8'h04: b = cmd1_q[7:0];
                  8'h05: b = cmd1_q[15:8];
                  8'h08: b = REVISION_ID;
                  8'h09: b = CLASS1[7:0];
                  8'h0A: b = CLASS1[15:8];
                  8'h0B: b = CLASS1[23:16];
                  8'h20: b = {disk_busmaster_base_address_q[7:4], 4'h1};
                  8'h21: b = disk_busmaster_base_address_q[15:8];
                  default: b = 8'h00;
               endcase
            end
            3'h2: begin
               case (off)
                  8'h00: b = MAKER_ID[7:0];
                  8'h01: b = MAKER_ID[15:8];
                  8'h02: b = PART_ID2[7:0];
                  8'h03: b = PART_ID2[15:8];
                  8'h04: b = cmd2_q[7:0];
                  8'h05: b = cmd2_q[15:8];
                  8'h08: b = REVISION_ID;
                  8'h09: b = CLASS2[7:0];
                  8'h0A: b = CLASS2[15:8];
                  8'h0B: b = CLASS2[23:16];
                  default: b = 8'h00;
               endcase
            end
            default: b = 8'h00;
         endcase
         cfg_rd[8*k +: 8] = b;
      end
   end

   // Status bits set by events, cleared by writing one
   always_comb begin
      stat_d = stat0_q;
      if (i_req_valid && i_req.cfg && i_req.wr && !i_req.isa_master && i_req.func == 3'h0 &&
          i_req.addr[7:2] == 6'h01) begin
         if (i_req.be[2]) begin
            stat_d[7:0] = stat_d[7:0] & ~i_req.wdata[23:16];
         end
         if (i_req.be[3]) begin
            stat_d[15:8] = stat_d[15:8] & ~i_req.wdata[31:24];
         end
      end
      stat_d = stat_d | i_status_set;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         stat0_q <= `PIBRD_STATUS_RESET;
      end else begin
         stat0_q <= stat_d;
      end
   end

   // Configuration writes
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         cmd0_q   <= `PIBRD_CMD_RESET;
         cmd1_q   <= `PIBRD_CMD_RESET;
         cmd2_q   <= `PIBRD_CMD_RESET;
         disk_busmaster_base_address_q  <= `PIBRD_BAR_RESET;
         serial_q <= `PIBRD_BAR_RESET;
         for (int j = 8'h40; j <= 8'hAF; j++) begin
            dev_q[j] <= `PIBRD_DEV_BYTE_RESET;
         end
      end else if (i_req_valid && i_req.cfg && i_req.wr && !i_req.isa_master) begin
         for (int k = 0; k < 4; k++) begin
            if (i_req.be[k]) begin
               case (i_req.func)
                  3'h0: begin
                     if (i_req.addr[7:2] == 6'h01 && k < 2) begin
                        cmd0_q[8*k +: 8] <= i_req.wdata[8*k +: 8];
                     end else if (dev_writable({i_req.addr[7:2], 2'(k)})) begin
                        dev_q[{i_req.addr[7:2], 2'(k)}] <= i_req.wdata[8*k +: 8];
                        if ({i_req.addr[7:2], 2'(k)} == 8'h5C) begin
                           serial_q[7:0] <= i_req.wdata[8*k +: 8];
                        end
                        if ({i_req.addr[7:2], 2'(k)} == 8'h5D) begin
                           serial_q[15:8] <= i_req.wdata[8*k +: 8];
                        end
                     end
                  end
                  3'h1: begin
                     if (i_req.addr[7:2] == 6'h01 && k < 2) begin
                        cmd1_q[8*k +: 8] <= i_req.wdata[8*k +: 8];
                     end else if (i_req.addr[7:2] == 6'h08 && k < 2) begin
                        disk_busmaster_base_address_q[8*k +: 8] <= i_req.wdata[8*k +: 8];
                     end
                  end
                  3'h2: begin
                     if (i_req.addr[7:2] == 6'h01 && k < 2) begin
                        cmd2_q[8*k +: 8] <= i_req.wdata[8*k +: 8];
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
      end
   end

   // Completion and claim
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_done            <= 1'b0;
         o_claim           <= 1'b0;
         o_decode          <= PIBRD_DEC_NONE;
         o_rdata           <= 32'h0000_0000;
         o_isa_byte_target <= 1'b0;
      end else begin
         o_done            <= i_req_valid;
         o_claim           <= 1'b0;
         o_decode          <= PIBRD_DEC_NONE;
         o_rdata           <= 32'h0000_0000;
         o_isa_byte_target <= 1'b0;
         if (i_req_valid && i_req.cfg) begin
            if (!i_req.isa_master && i_req.func <= `PIBRD_LAST_CLAIMED_FN) begin
               o_claim  <= 1'b1;
               o_decode <= PIBRD_DEC_POSITIVE;
               o_rdata  <= i_req.wr ? 32'h0000_0000 : cfg_rd;
            end
         end else if (i_req_valid) begin
            o_claim           <= (dec == PIBRD_DEC_POSITIVE);
            o_decode          <= dec;
            o_isa_byte_target <= i_req.isa_master && dec != PIBRD_DEC_NONE;
         end
      end
   end

   // Broadcast onto the ISA bus
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_isa_bcast    <= 1'b0;
         o_isa_bcast_wr <= 1'b0;
      end else begin
         o_isa_bcast    <= i_req_valid && !i_req.cfg && bcast;
         o_isa_bcast_wr <= i_req_valid && !i_req.cfg && bcast && i_req.wr;
      end
   end

   // Access to internal units
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_unit_sel   <= PIBRD_UNIT_NONE;
         o_unit_wr    <= 1'b0;
         o_unit_addr  <= 16'h0000;
         o_unit_wdata <= 32'h0000_0000;
         o_unit_be    <= 4'h0;
         o_alias_en   <= 1'b0;
      end else begin
         o_alias_en   <= alias_en;
         o_unit_sel   <= PIBRD_UNIT_NONE;
         o_unit_wr    <= 1'b0;
         o_unit_addr  <= 16'h0000;
         o_unit_wdata <= 32'h0000_0000;
         o_unit_be    <= 4'h0;
         if (i_req_valid && !i_req.cfg && unit != PIBRD_UNIT_NONE) begin
            o_unit_sel <= unit;
            o_unit_wr  <= i_req.wr;
            if (unit == PIBRD_UNIT_DISK_BM || unit == PIBRD_UNIT_SERIAL) begin
               o_unit_addr  <= i_req.addr;
               o_unit_wdata <= i_req.wdata;
               o_unit_be    <= i_req.be;
            end else begin
               o_unit_addr  <= io_addr;
               o_unit_wdata <= {24'h00_0000, i_req.wdata[8*lane +: 8]};
               o_unit_be    <= 4'h1;
               if (alias_en && io_addr[15:4] == 12'h009) begin
                  o_unit_addr <= {io_addr[15:8], 4'h8, io_addr[3:0]};
               end
            end
         end
      end
   end

endmodule : pibrd_decode

//--- shared/pibrd_consts.svh
// Offsets, field positions and reset values for the bridge register decoder
`ifndef PIBRD_CONSTS_SVH
`define PIBRD_CONSTS_SVH

// Function 0 configuration offsets, and BAR0 of function 1
`define PIBRD_CFG_MAKER_ID      8'h00
`define PIBRD_CFG_PART_ID       8'h02
`define PIBRD_CFG_COMMAND       8'h04
`define PIBRD_CFG_STATUS        8'h06
`define PIBRD_CFG_REVISION      8'h08
`define PIBRD_CFG_CLASS         8'h09
`define PIBRD_CFG_HEADER        8'h0E
`define PIBRD_CFG_BAR0          8'h20
`define PIBRD_CFG_RECOVERY      8'h4C
`define PIBRD_CFG_XBUS_CS       8'h4E
`define PIBRD_CFG_SERIAL_BASE   8'h5C
`define PIBRD_CFG_IRQ_ROUTE     8'h60
`define PIBRD_CFG_TOP_MEM       8'h69
`define PIBRD_CFG_MISC_STAT     8'h6A
`define PIBRD_CFG_BRD_IRQ0      8'h70
`define PIBRD_CFG_BRD_IRQ1      8'h71
`define PIBRD_CFG_BRD_DMA       8'h76
`define PIBRD_CFG_PROG_CS       8'h78
`define PIBRD_CFG_IOAPIC_BASE   8'h80
`define PIBRD_CFG_LATENCY       8'h82
`define PIBRD_CFG_SMI_CTRL      8'hA0
`define PIBRD_CFG_SMI_EN        8'hA2
`define PIBRD_CFG_EVENT_EN      8'hA4
`define PIBRD_CFG_FAST_OFF      8'hA8
`define PIBRD_CFG_SMI_REQ       8'hAA
`define PIBRD_CFG_STOP_LOW      8'hAC
`define PIBRD_CFG_STOP_HIGH     8'hAE
`define PIBRD_CFG_DEV_LO        8'h40
`define PIBRD_CFG_DEV_HI        8'hAF

// Field positions
`define PIBRD_CMD_IO_EN         0
`define PIBRD_RECOV_ALIAS_EN    6

// Reset values
`define PIBRD_CMD_RESET         16'h0000
`define PIBRD_STATUS_RESET      16'h0000
`define PIBRD_DEV_BYTE_RESET    8'h00
`define PIBRD_BAR_RESET         16'h0000

// I/O decode windows
`define PIBRD_BM_WIN_BITS       4
`define PIBRD_SERIAL_WIN_BITS   5
`define PIBRD_PM_PORT_A         16'h00B2
`define PIBRD_PM_PORT_B         16'h00B3
`define PIBRD_LAST_CLAIMED_FN   3'h2

`endif

//--- shared/pibrd_pkg.sv
// Types for the bridge register decoder
package pibrd_pkg;

   typedef struct packed {
      logic        cfg;
      logic        wr;
      logic        isa_master;
      logic [2:0]  func;
      logic [15:0] addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } pibrd_req_t;

   typedef enum logic [2:0] {
      PIBRD_UNIT_NONE,
      PIBRD_UNIT_COMPAT,
      PIBRD_UNIT_DMA,
      PIBRD_UNIT_PM,
      PIBRD_UNIT_DISK_BM,
      PIBRD_UNIT_SERIAL
   } pibrd_unit_t;

   typedef enum logic [1:0] {
      PIBRD_DEC_NONE,
      PIBRD_DEC_POSITIVE,
      PIBRD_DEC_SUBTRACTIVE
   } pibrd_dec_t;

endpackage : pibrd_pkg

//--- bench/pibrd_decode_checker.sv
// Port assertions for the bridge register decoder
`timescale 1ns/10ps
module pibrd_decode_checker
   import pibrd_pkg::*;
(
   // Clock and reset
   input wire logic        i_ref_clk,
   input wire logic        i_srst,
   // Request
   input wire logic        i_req_valid,
   input wire pibrd_req_t  i_req,
   // Completion
   input wire logic        o_done,
   input wire logic        o_claim,
   input wire pibrd_dec_t  o_decode,
   input wire logic        o_isa_byte_target,
   input wire logic        o_isa_bcast,
   input wire logic        o_isa_bcast_wr,
   input wire pibrd_unit_t o_unit_sel,
   input wire logic [3:0]  o_unit_be,
   input wire logic        o_alias_en
);
   logic [1:0]  ln;
   logic [15:0] a;
   logic        io, pci, bc, lo, wr_q;
   always_comb begin
      ln  = i_req.be[0] ? 2'h0 : i_req.be[1] ? 2'h1 : i_req.be[2] ? 2'h2 : 2'h3;
      a   = {i_req.addr[15:2], ln};
      lo  = a[15:8] == 8'h00;
      io  = i_req_valid && !i_req.cfg && (|i_req.be);
      pci = io && !i_req.isa_master;
      bc  = pci && (a inside {16'h0070, 16'h00F0} || (i_req.wr && a[15:5] == 11'h004
            && a[3:0] inside {4'h0, 4'h4, 4'h5, 4'h6, 4'h8, 4'hC, 4'hD, 4'hE}));
   end
   always_ff @(posedge i_ref_clk) begin
      wr_q <= i_req.wr;
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);
   a_done_next: assert property (i_req_valid |=> o_done) else $error("no completion");
   a_done_cause: assert property (o_done |-> $past(i_req_valid)) else $error("stray completion");
   a_high_fn: assert property (i_req_valid && i_req.cfg && i_req.func > 3'h2 |=>
      !o_claim && o_decode == PIBRD_DEC_NONE) else $error("high function claimed");
   a_cfg_claim: assert property (i_req_valid && i_req.cfg && !i_req.isa_master && i_req.func <= 3'h2
      |=> o_claim) else $error("config not claimed");
   a_isa_cfg: assert property (i_req_valid && i_req.cfg && i_req.isa_master |=> !o_claim)
      else $error("isa config claimed");
   a_dma_sub: assert property (pci && lo && (a[7:4] inside {4'h0, 4'h8} || a[7:5] == 3'h6)
      |=> o_decode == PIBRD_DEC_SUBTRACTIVE && !o_claim) else $error("dma not subtractive");
   a_compat_pos: assert property (pci && lo && a[7:0] inside {8'h20, 8'h21, 8'h40, 8'h41, 8'h42, 8'h43,
      8'h60, 8'h61, 8'h70, 8'hA0, 8'hA1, 8'hF0} |=> o_decode == PIBRD_DEC_POSITIVE && o_claim)
      else $error("compat not positive");
   a_bcast_list: assert property (bc |=> o_isa_bcast && o_isa_bcast_wr == wr_q)
      else $error("broadcast missing");
   a_bcast_none: assert property (i_req_valid && !bc |=> !o_isa_bcast) else $error("stray broadcast");
   a_low_byte: assert property (o_unit_sel inside {PIBRD_UNIT_COMPAT, PIBRD_UNIT_DMA, PIBRD_UNIT_PM}
      |-> o_unit_be == 4'h1) else $error("wide compat access");
   a_isa_byte: assert property (io && i_req.isa_master && lo && a[7:0] inside {8'h20, 8'h21, 8'h40, 8'h41,
      8'h42, 8'h43, 8'h60, 8'h61} |=> o_isa_byte_target) else $error("isa not byte target");
   a_alias_map: assert property (pci && o_alias_en && a[15:4] == 12'h009
      |=> o_unit_sel == PIBRD_UNIT_DMA) else $error("alias not applied");
   c_bcast: cover property (bc);
   c_high_fn: cover property (i_req_valid && i_req.cfg && i_req.func > 3'h2);
   c_disk: cover property (o_unit_sel == PIBRD_UNIT_DISK_BM);
endmodule : pibrd_decode_checker

bind pibrd_decode pibrd_decode_checker u_chk (.i_ref_clk, .i_srst, .i_req_valid, .i_req, .o_done, .o_claim,
   .o_decode, .o_isa_byte_target, .o_isa_bcast, .o_isa_bcast_wr, .o_unit_sel, .o_unit_be, .o_alias_en);

//--- bench/pibrd_host_model.sv
// Host bus master model issuing requests to the decoder
`timescale 1ns/10ps
module pibrd_host_model
   import pibrd_pkg::*;
(
   // Clock
   input  wire logic        i_ref_clk,
   // Request
   output logic             o_req_valid,
   output pibrd_req_t       o_req,
   // Completion
   input  wire logic        i_done,
   input  wire logic [31:0] i_rdata
);
   logic        done_q;
   logic [31:0] rdata_q;
   initial begin
      o_req_valid = 1'b0;
      o_req       = '0;
   end
   task automatic xfer(input logic c, w, s, input logic [2:0] f, input logic [15:0] a,
                       input logic [3:0] b, input logic [31:0] d);
      pibrd_req_t r;
      r = '{cfg: c, wr: w, isa_master: s, func: f, addr: a, be: b, wdata: d};
      if (!c && a[15:2] == 14'h002C) begin
         r.be = b & (~b + 4'h1); // Power ports single byte
      end
      @(negedge i_ref_clk);
      o_req_valid = 1'b1;
      o_req       = r;
      @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      done_q      = i_done;
      rdata_q     = i_rdata;
      o_req_valid = 1'b0;
      o_req       = ~r;
   endtask : xfer
endmodule : pibrd_host_model

//--- bench/pibrd_decode_bench.sv
// Self-checking bench for the bridge register decoder
`timescale 1ns/10ps
module pibrd_decode_bench;
   import pibrd_pkg::*;
   localparam logic [15:0] MK = 16'h5A17; // Arbitrary value
   localparam logic [15:0] PT [3] = '{16'h0A01, 16'h0A02, 16'h0A03}; // Arbitrary values
   localparam logic [7:0]  RW_OFF [11] = '{8'h4C, 8'h60, 8'h68, 8'h70, 8'h74, 8'h78, 8'h80, 8'hA0, 8'hA4,
                                           8'hA8, 8'hAC};
   localparam logic [31:0] RW_MSK [11] = '{32'hFFFF_00FF, 32'hFFFF_FFFF, 32'hFFFF_FF00, 32'h0000_FFFF,
      32'hFFFF_0000, 32'h0000_FFFF, 32'h00FF_00FF, 32'hFFFF_00FF, 32'hFFFF_FFFF, 32'hFFFF_00FF, 32'h00FF_00FF};
   logic        i_ref_clk, i_srst, i_req_valid;
   pibrd_req_t  i_req;
   logic [15:0] i_status_set, o_unit_addr;
   logic        o_done, o_claim, o_isa_byte_target, o_isa_bcast, o_isa_bcast_wr, o_unit_wr, o_alias_en;
   pibrd_dec_t  o_decode;
   pibrd_unit_t o_unit_sel;
   logic [31:0] o_rdata, o_unit_wdata, seed;
   logic [3:0]  o_unit_be;
   int          failures, n_tests;

   pibrd_decode #(.MAKER_ID(MK), .PART_ID0(PT[0]), .PART_ID1(PT[1]), .PART_ID2(PT[2])) uut (.i_ref_clk,
      .i_srst, .i_req_valid, .i_req, .i_status_set, .o_done, .o_claim, .o_decode, .o_rdata,
      .o_isa_byte_target, .o_isa_bcast, .o_isa_bcast_wr, .o_unit_sel, .o_unit_wr, .o_unit_addr,
      .o_unit_wdata, .o_unit_be, .o_alias_en);
   pibrd_host_model host (.i_ref_clk, .o_req_valid(i_req_valid), .o_req(i_req), .i_done(o_done),
      .i_rdata(o_rdata));

   initial i_ref_clk = 1'b0;
   always #25 i_ref_clk = ~i_ref_clk;

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs

   function automatic pibrd_unit_t exp_unit(input logic [15:0] a, input logic s, al);
      logic lo;
      lo = a[15:8] == 8'h00;
      if (lo && (a[7:0] inside {8'h20, 8'h21, 8'h60, 8'h61} || a[7:2] == 6'h10)) return PIBRD_UNIT_COMPAT;
      if (s) return PIBRD_UNIT_NONE;
      if (lo && !s && a[7:0] inside {8'h70, 8'hA0, 8'hA1, 8'hF0}) return PIBRD_UNIT_COMPAT;
      if (lo && a[7:1] == 7'h59) return PIBRD_UNIT_PM;
      if (lo && (a[7:4] inside {4'h0, 4'h8} || a[7:5] == 3'h6 || (al && a[7:4] == 4'h9))) return PIBRD_UNIT_DMA;
      return PIBRD_UNIT_NONE;
   endfunction : exp_unit

   task automatic chk(input logic [31:0] g, e);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic cfg(input logic w, input logic [2:0] f, input logic [7:0] o, input logic [3:0] b,
                      input logic [31:0] d);
      host.xfer(1'b1, w, 1'b0, f, {8'h00, o}, b, d);
      chk(32'(o_done), 32'h1);
   endtask : cfg

   task automatic io_chk(input logic s, w, input logic [15:0] a, input logic [3:0] b, input logic [31:0] d,
                         input logic al);
      logic [1:0]  ln;
      logic [15:0] e;
      pibrd_unit_t u;
      logic        bc;
      ln = b[0] ? 2'h0 : b[1] ? 2'h1 : b[2] ? 2'h2 : 2'h3;
      e  = {a[15:2], ln};
      u  = exp_unit(e, s, al);
      bc = !s && (e inside {16'h0070, 16'h00F0} || (w && e[15:5] == 11'h004
           && e[3:0] inside {4'h0, 4'h4, 4'h5, 4'h6, 4'h8, 4'hC, 4'hD, 4'hE}));
      if (al && e[15:4] == 12'h009) e[4] = 1'b0;
      host.xfer(1'b0, w, s, 3'h0, a, b, d);
      chk(32'(o_decode), 32'(u == PIBRD_UNIT_NONE ? PIBRD_DEC_NONE : u == PIBRD_UNIT_DMA ?
          PIBRD_DEC_SUBTRACTIVE : PIBRD_DEC_POSITIVE));
      chk(32'(o_claim), 32'(u != PIBRD_UNIT_NONE && u != PIBRD_UNIT_DMA));
      chk(32'(o_unit_sel), 32'(u));
      chk({30'h0, o_isa_bcast, o_isa_bcast_wr}, {30'h0, bc, bc && w});
      chk(32'(o_isa_byte_target), 32'(s && u != PIBRD_UNIT_NONE));
      chk(o_rdata, 32'h0);
      if (u != PIBRD_UNIT_NONE) begin
         chk({o_unit_addr, 11'h0, o_unit_wr, o_unit_be}, {e, 11'h0, w, 4'h1});
         chk(32'(o_unit_wdata[7:0]), (d >> (8 * ln)) & 32'hFF);
      end
   endtask : io_chk

   task automatic end_of_test();
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test

   initial begin
      #(50 * 5000);
      failures++;
      end_of_test();
   end

   initial begin
      logic [3:0] b;
      failures = 0;
      n_tests = 0;
      seed = 32'h0000_6496;
      i_srst = 1'b1;
      i_status_set = 16'h0000;
      repeat (6) @(negedge i_ref_clk);
      i_srst = 1'b0;
      // Function claims and identity
      for (int f = 0; f < 8; f++) begin
         cfg(1'b0, f[2:0], 8'h00, 4'hF, 32'h0);
         chk(32'(o_claim), 32'(f < 3));
         if (f < 3) chk(o_rdata, {PT[f % 3], MK});
      end
      host.xfer(1'b1, 1'b0, 1'b1, 3'h0, 16'h0000, 4'hF, 32'h0);
      chk(32'(o_claim), 32'h0);
      // Defaults and reserved places
      for (int o = 32'h40; o < 32'hB0; o += 4) begin
         cfg(1'b0, 3'h0, 8'(o), 4'hF, 32'h0);
         chk({31'h0, o_claim, o_rdata}, {31'h0, 1'b1, 32'h0});
      end
      cfg(1'b1, 3'h0, 8'h00, 4'hF, ~{PT[0], MK});
      cfg(1'b0, 3'h0, 8'h00, 4'hF, 32'h0);
      chk(o_rdata, {PT[0], MK});
      cfg(1'b1, 3'h0, 8'h0C, 4'hF, 32'hFFFF_FFFF);
      cfg(1'b0, 3'h0, 8'h0C, 4'hF, 32'h0);
      chk(o_rdata, 32'h0080_0000);
      // Status bits
      @(negedge i_ref_clk) i_status_set = 16'h8001;
      @(negedge i_ref_clk) i_status_set = 16'h0000;
      for (int i = 0; i < 2; i++) begin
         cfg(1'b1, 3'h0, 8'h04, 4'hC, i == 0 ? 32'h0001_0000 : 32'h0);
         cfg(1'b0, 3'h0, 8'h04, 4'hF, 32'h0);
         chk(o_rdata, 32'h8000_0000);
      end
      // Read-write registers
      for (int i = 0; i < 11; i++) begin
         seed = xs(seed);
         for (int k = 0; k < 4; k++) b[k] = |RW_MSK[i][8 * k +: 8];
         cfg(1'b1, 3'h0, RW_OFF[i], b, seed);
         cfg(1'b0, 3'h0, RW_OFF[i], 4'hF, 32'h0);
         chk(o_rdata, seed & RW_MSK[i]);
      end
      @(negedge i_ref_clk) i_srst = 1'b1;
      repeat (6) @(negedge i_ref_clk);
      i_srst = 1'b0;
      cfg(1'b0, 3'h0, 8'h4C, 4'hF, 32'h0);
      chk(o_rdata, 32'h0);
      // I/O decode, alias on then off
      for (int al = 1; al >= 0; al--) begin
         cfg(1'b1, 3'h0, 8'h4C, 4'h1, al ? 32'h40 : 32'h0);
         @(negedge i_ref_clk) chk(32'(o_alias_en), 32'(al));
         io_chk(1'b0, 1'b0, 16'h0070, 4'h1, 32'h0, al[0]);
         io_chk(1'b0, 1'b1, 16'h009C, 4'h2, 32'h1234_5678, al[0]);
         io_chk(1'b1, 1'b1, 16'h0070, 4'h1, 32'h0, al[0]);
         repeat (150) begin
            seed = xs(seed);
            b = seed[11:8] == 4'h0 ? 4'h1 : seed[11:8];
            io_chk(seed[13], seed[12], {8'h00, seed[7:2], 2'h0}, b, {seed[15:0], seed[31:16]}, al[0]);
         end
      end
      // Relocatable windows
      cfg(1'b1, 3'h1, 8'h20, 4'hF, 32'h0000_1000);
      cfg(1'b1, 3'h1, 8'h04, 4'h1, 32'h0000_0001);
      cfg(1'b0, 3'h1, 8'h20, 4'hF, 32'h0);
      chk(o_rdata, 32'h0000_1001);
      cfg(1'b1, 3'h0, 8'h5C, 4'h3, 32'h0000_2000);
      cfg(1'b1, 3'h2, 8'h04, 4'h1, 32'h0000_0001);
      host.xfer(1'b0, 1'b1, 1'b0, 3'h0, 16'h100C, 4'h6, 32'hA1B2_C3D4);
      chk({28'(o_unit_sel), o_unit_be}, {28'(PIBRD_UNIT_DISK_BM), 4'h6});
      chk(o_unit_wdata, 32'hA1B2_C3D4);
      host.xfer(1'b0, 1'b0, 1'b0, 3'h0, 16'h201C, 4'hF, 32'h0);
      chk(32'(o_unit_sel), 32'(PIBRD_UNIT_SERIAL));
      io_chk(1'b0, 1'b1, 16'h1010, 4'hF, 32'h0, 1'b0);
      io_chk(1'b0, 1'b0, 16'h2020, 4'h1, 32'h0, 1'b0);
      end_of_test();
   end
endmodule : pibrd_decode_bench
